// *** design/idbus_pkg.sv ***
/*
 * Package for the single-wire identity-bus host controller: register map
 * of the controller, the far device's status-memory map, line timing and
 * command codes.
 * Assumes a 50 MHz clock and a single open-drain data line with pull-up.
 */
package idbus_pkg;

    // ****************************************************************
    // clock and line timing
    // ****************************************************************
    localparam int CLK_MHZ = 50;
    localparam int T_RESET_US = 480;
    localparam int T_RESET_CYC = T_RESET_US * CLK_MHZ;
    localparam int T_PRES_WAIT_US = 480;
    localparam int T_PRES_WAIT_CYC = T_PRES_WAIT_US * CLK_MHZ;
    localparam int T_PPD_MIN_US = 15;
    localparam int T_PPD_MIN_CYC = T_PPD_MIN_US * CLK_MHZ;
    localparam int T_PPD_PP_MAX_US = 300;
    localparam int T_PPD_PP_MAX_CYC = T_PPD_PP_MAX_US * CLK_MHZ;
    localparam int T_SLOT_US = 70;
    localparam int T_SLOT_CYC = T_SLOT_US * CLK_MHZ;
    localparam int T_W1_LOW_US = 6;
    localparam int T_W1_LOW_CYC = T_W1_LOW_US * CLK_MHZ;
    localparam int T_W0_LOW_US = 62;
    localparam int T_W0_LOW_CYC = T_W0_LOW_US * CLK_MHZ;
    localparam int T_RD_LOW_US = 2;
    localparam int T_RD_LOW_CYC = T_RD_LOW_US * CLK_MHZ;
    localparam int T_RD_SAMPLE_NS = 11000;
    localparam int T_RD_SAMPLE_CYC = T_RD_SAMPLE_NS * CLK_MHZ / 1000;
    localparam int T_REC_US = 5;
    localparam int T_REC_CYC = T_REC_US * CLK_MHZ;

    // ****************************************************************
    // commands and CRC
    // ****************************************************************
    localparam logic [7:0] CMD_READ_ID = 8'h33;
    localparam logic [7:0] CMD_BYPASS = 8'hCC;
    localparam logic [7:0] CRC_POLY_REFL = 8'h8C;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // ****************************************************************
    // device memory map (far side, kept for software)
    // ****************************************************************
    localparam logic [7:0] PAGE0_BASE = 8'h00;
    localparam logic [7:0] PAGE1_BASE = 8'h20;
    localparam logic [7:0] PAGE2_BASE = 8'h40;
    localparam logic [7:0] PAGE3_BASE = 8'h60;
    localparam logic [7:0] PAGE_BYTES = 8'h20;
    localparam logic [7:0] PROG_BUF_BYTES = 8'h08;
    localparam logic [7:0] ST_PAGE_WRITE_LOCK_FLAGS = 8'h00;
    localparam logic [7:0] ST_PAGE0_REDIRECT = 8'h01;
    localparam logic [7:0] ST_PAGE1_REDIRECT = 8'h02;
    localparam logic [7:0] ST_PAGE2_REDIRECT = 8'h03;
    localparam logic [7:0] ST_PAGE3_REDIRECT = 8'h04;
    localparam logic [7:0] ST_STATUS_SPARE_A = 8'h05;
    localparam logic [7:0] ST_STATUS_SPARE_B = 8'h06;
    localparam logic [7:0] ST_FACTORY_FIXED_BYTE = 8'h07;
    localparam logic [7:0] FACTORY_FIXED_VALUE = 8'h00;
    localparam logic [7:0] REDIRECT_NONE = 8'hFF; // (RULE9)

    // ****************************************************************
    // controller registers (byte addresses)
    // ****************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ID_LO = 8'h08;
    localparam logic [7:0] REG_ID_HI = 8'h0C;
    localparam logic [7:0] REG_TXDATA = 8'h10;
    localparam logic [7:0] REG_RXDATA = 8'h14;
    localparam int CTRL_RESET_BIT = 0;
    localparam int CTRL_READ_ID_BIT = 1;
    localparam int CTRL_WRITE_BYTE_BIT = 2;
    localparam int CTRL_READ_BYTE_BIT = 3;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_PRESENT_BIT = 1;
    localparam int ST_CRC_OK_BIT = 2;
    localparam int ST_DONE_BIT = 3;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } wb_req_s;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0000,
        S_RST_LOW = 4'b0001,
        S_PRES_WAIT = 4'b0010,
        S_TX_LOW = 4'b0011,
        S_TX_SLOT = 4'b0100,
        S_RX_LOW = 4'b0101,
        S_RX_SLOT = 4'b0110,
        S_REC = 4'b0111,
        S_NEXT = 4'b1000
    } line_state_e;

endpackage

// *** design/idbus_host.sv ***
/*
 * Host controller for a single-wire identity/OTP device. Issues the line
 * reset, detects presence, sends bytes, reads bytes and fetches the 64-bit
 * identity with CRC check. Software drives it over classic Wishbone.
 * Assumes an external pull-up on the line; this end only pulls low.
 */
// Contract
// (RULE1) identity is 8-bit family, 48-bit serial, 8-bit CRC over them
// (RULE2) device data memory is four 32-byte pages at 00h,20h,40h,60h
// (RULE3) programming loads 8-byte buffer, CRC returned, then commit command
// (RULE4) separate 64-bit status memory reached by its own commands
// (RULE5) status byte 00h: bits 0-3 page locks, bits 4-7 used-page map
// (RULE6) locked page cannot be altered but still reads back
// (RULE7) lock flags change only through the status-write command
// (RULE8) status bytes 01h-04h are page redirection bytes, stored only
// (RULE9) host: FFh means page valid, else data at inverse of byte
// (RULE10) status 05h,06h reserved; 07h fixed to 00h
// (RULE11) check bytes use CRC x^8+x^5+x^4+1; host flags mismatch
// (RULE12) line is open drain; host supplies the high level; this end only pulls low and relies on an external pull-up
// (RULE13) each transaction opens with host low at least 480 us
// (RULE14) after presence, command 33h returns family, serial, CRC
// (RULE15) every byte goes least significant bit first
// (RULE16) device waits 15-60 us then pulls low 60-240 us presence
// (RULE17) bypass command CCh precedes memory and status commands
// (RULE18) CRC cleared to zero, bits shifted in LSB first
`timescale 1ns/1ps
module idbus_host
    import idbus_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // single-wire line
    input wire logic line_i,
    output logic line_o,
    output logic line_oe_o
);

    // ****************************************************************
    // pin synchroniser
    // ****************************************************************
    logic line_meta_reg;
    logic line_sync_reg;

    always_ff @(posedge clk_i) begin
        line_meta_reg <= line_i;
        line_sync_reg <= line_meta_reg;
    end

    // ****************************************************************
    // bus decode
    // ****************************************************************
    wb_req_s req;
    logic ack_reg;
    logic [31:0] rdat_reg;
    assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i,
                   adr: adr_i, dat: dat_i};
    wire bus_hit = req.cyc && req.stb && !ack_reg;
    // writes commit on the edge where the master sees ack, not before
    wire bus_wr = req.cyc && req.stb && req.we && ack_reg;
    wire wr_ctrl = bus_wr && req.sel[0] && req.adr == REG_CTRL;
    wire wr_tx = bus_wr && req.sel[0] && req.adr == REG_TXDATA;

    line_state_e state_reg;
    logic [17:0] tmr_reg;
    logic [2:0] bit_reg;
    logic [3:0] byte_reg;
    logic [3:0] nbytes_reg;
    logic rx_mode_reg;
    logic id_mode_reg;
    logic present_reg;
    logic done_reg;
    logic crc_ok_reg;
    logic [7:0] tx_reg;
    logic [7:0] sh_reg;
    logic [7:0] crc_reg;
    logic [63:0] id_reg;
    logic sampled_reg;

    wire busy = state_reg != S_IDLE;
    wire [31:0] status_word = {28'h0000000, done_reg, crc_ok_reg,
                               present_reg, busy};
    wire go = wr_ctrl && !busy;
    wire [7:0] tx_next = id_mode_reg ? CMD_READ_ID : tx_reg;
    wire tx_bit = sh_reg[0]; // (RULE15)
    wire crc_fb = crc_reg[0] ^ sampled_reg;
    // (RULE11) (RULE18) reflected form of x^8+x^5+x^4+1, LSB first
    wire [7:0] crc_next = {1'b0, crc_reg[7:1]} ^ (crc_fb ? CRC_POLY_REFL
                                                       : 8'h00);
    wire [7:0] rx_byte = {sampled_reg, sh_reg[7:1]};
    wire tmr_zero = tmr_reg == 18'h00000;
    wire last_bit = bit_reg == 3'h7;

    always_comb begin
        case (req.adr)
            REG_CTRL: rdat_reg = 32'h00000000;
            REG_STATUS: rdat_reg = status_word;
            REG_ID_LO: rdat_reg = id_reg[31:0];
            REG_ID_HI: rdat_reg = id_reg[63:32];
            REG_TXDATA: rdat_reg = {24'h000000, tx_reg};
            REG_RXDATA: rdat_reg = {24'h000000, sh_reg};
            default: rdat_reg = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_reg <= bus_hit;
            dat_o <= bus_hit ? rdat_reg : 32'h00000000;
        end
    end
    assign ack_o = ack_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_reg <= 8'h00;
        end else if (wr_tx) begin
            tx_reg <= req.dat[7:0];
        end
    end

    // ****************************************************************
    // line sequencer
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= S_IDLE;
            tmr_reg <= 18'h00000;
            bit_reg <= 3'h0;
            byte_reg <= 4'h0;
            nbytes_reg <= 4'h0;
            rx_mode_reg <= 1'b0;
            id_mode_reg <= 1'b0;
            present_reg <= 1'b0;
            done_reg <= 1'b0;
            crc_ok_reg <= 1'b0;
            sh_reg <= 8'h00;
            crc_reg <= 8'h00;
            id_reg <= 64'h0000000000000000;
            sampled_reg <= 1'b1;
            line_oe_o <= 1'b0;
        end else begin
            if (!tmr_zero) begin
                tmr_reg <= tmr_reg - 18'h00001;
            end
            case (state_reg)
                S_IDLE: begin
                    line_oe_o <= 1'b0;
                    bit_reg <= 3'h0;
                    if (go && req.dat[CTRL_RESET_BIT]) begin
                        // (RULE13) (RULE14) id fetch always opens with reset
                        id_mode_reg <= req.dat[CTRL_READ_ID_BIT];
                        present_reg <= 1'b0;
                        done_reg <= 1'b0;
                        line_oe_o <= 1'b1; // (RULE12)
                        tmr_reg <= 18'(T_RESET_CYC);
                        state_reg <= S_RST_LOW;
                    end else if (go && req.dat[CTRL_WRITE_BYTE_BIT]) begin
                        // (RULE3) buffer load and commit are byte writes
                        done_reg <= 1'b0;
                        rx_mode_reg <= 1'b0;
                        nbytes_reg <= 4'h1;
                        byte_reg <= 4'h0;
                        sh_reg <= tx_reg; // (RULE17) software sends CCh here
                        state_reg <= S_NEXT;
                    end else if (go && req.dat[CTRL_READ_BYTE_BIT]) begin
                        done_reg <= 1'b0;
                        rx_mode_reg <= 1'b1;
                        nbytes_reg <= 4'h1;
                        byte_reg <= 4'h0;
                        state_reg <= S_NEXT;
                    end
                end
                S_RST_LOW: begin
                    if (tmr_zero) begin
                        line_oe_o <= 1'b0;
                        tmr_reg <= 18'(T_PRES_WAIT_CYC);
                        state_reg <= S_PRES_WAIT;
                    end
                end
                S_PRES_WAIT: begin
                    // (RULE16) low seen after the earliest presence delay
                    if (!line_sync_reg && tmr_reg <
                        18'(T_PRES_WAIT_CYC - T_PPD_MIN_CYC) &&
                        tmr_reg > 18'(T_PRES_WAIT_CYC - T_PPD_PP_MAX_CYC)) begin
                        present_reg <= 1'b1;
                    end
                    if (tmr_zero) begin
                        if (id_mode_reg && present_reg) begin
                            sh_reg <= tx_next;
                            rx_mode_reg <= 1'b0;
                            nbytes_reg <= 4'h1;
                            byte_reg <= 4'h0;
                            state_reg <= S_NEXT;
                        end else begin
                            done_reg <= 1'b1;
                            state_reg <= S_IDLE;
                        end
                    end
                end
                S_NEXT: begin
                    line_oe_o <= 1'b1;
                    if (rx_mode_reg) begin
                        tmr_reg <= 18'(T_RD_LOW_CYC);
                        state_reg <= S_RX_LOW;
                    end else begin
                        tmr_reg <= tx_bit ? 18'(T_W1_LOW_CYC)
                                          : 18'(T_W0_LOW_CYC);
                        state_reg <= S_TX_LOW;
                    end
                end
                S_TX_LOW: begin
                    if (tmr_zero) begin
                        line_oe_o <= 1'b0;
                        // pad to a full slot whatever the low time was
                        tmr_reg <= tx_bit ? 18'(T_SLOT_CYC - T_W1_LOW_CYC)
                                          : 18'(T_SLOT_CYC - T_W0_LOW_CYC);
                        state_reg <= S_TX_SLOT;
                    end
                end
                S_TX_SLOT: begin
                    if (tmr_zero) begin
                        // read slots shift in S_REC instead
                        if (!rx_mode_reg) begin
                            sh_reg <= {1'b0, sh_reg[7:1]};
                        end
                        tmr_reg <= 18'(T_REC_CYC);
                        state_reg <= S_REC;
                    end
                end
                S_RX_LOW: begin
                    if (tmr_zero) begin
                        line_oe_o <= 1'b0;
                        tmr_reg <= 18'(T_RD_SAMPLE_CYC - T_RD_LOW_CYC);
                        state_reg <= S_RX_SLOT;
                    end
                end
                S_RX_SLOT: begin
                    if (tmr_zero) begin
                        sampled_reg <= line_sync_reg;
                        tmr_reg <= 18'(T_SLOT_CYC - T_RD_SAMPLE_CYC);
                        state_reg <= S_TX_SLOT;
                        rx_mode_reg <= 1'b1;
                    end
                end
                S_REC: begin
                    if (tmr_zero) begin
                        if (rx_mode_reg) begin
                            sh_reg <= rx_byte; // (RULE15)
                            if (id_mode_reg) begin
                                crc_reg <= crc_next;
                            end
                        end
                        bit_reg <= bit_reg + 3'h1;
                        if (!last_bit) begin
                            state_reg <= S_NEXT;
                        end else if (id_mode_reg && !rx_mode_reg) begin
                            // (RULE1) (RULE18) command sent, read 8 bytes
                            rx_mode_reg <= 1'b1;
                            crc_reg <= CRC_INIT;
                            byte_reg <= 4'h0;
                            nbytes_reg <= 4'h8;
                            state_reg <= S_NEXT;
                        end else begin
                            if (id_mode_reg) begin
                                id_reg <= {rx_byte, id_reg[63:8]};
                            end
                            byte_reg <= byte_reg + 4'h1;
                            if (byte_reg + 4'h1 < nbytes_reg) begin
                                state_reg <= S_NEXT;
                            end else begin
                                // (RULE11) residue zero once CRC byte is in
                                crc_ok_reg <= id_mode_reg && crc_next
                                              == 8'h00;
                                id_mode_reg <= 1'b0;
                                done_reg <= 1'b1;
                                state_reg <= S_IDLE;
                            end
                        end
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // line driven low only; pull-up gives the high level
    assign line_o = 1'b0;

endmodule

// *** verif/idbus_dev_model.sv ***
/*
 * Behavioural model of the single-wire identity device on the far side.
 * Assumes the bench resolves the wire from both pull-downs plus a pull-up.
 */
`timescale 1ns/1ps
module idbus_dev_model #(
    parameter logic [63:0] ID_VALUE = 64'h0
) (
    input wire logic line_i,
    input wire logic present_i,
    output logic pull_o
);
    // ****************************************************************
    // state
    // ****************************************************************
    realtime fall_t = 0.0;
    realtime rst_ns = 0.0;
    logic [7:0] cmd_bits = 8'h00;
    int bit_n = -1;
    // status memory: lock flags, redirects, spares, fixed byte
    logic [7:0] st_mem [8] = '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'h00};
    initial pull_o = 1'b0;

    // ****************************************************************
    // slots: command bits in, identity bits out
    // ****************************************************************
    always @(negedge line_i) begin
        fall_t = $realtime;
        if (!pull_o && bit_n >= 0 && bit_n < 8) begin
            #30000;
            cmd_bits = {line_i, cmd_bits[7:1]};
            bit_n++;
            if (bit_n == 8 && cmd_bits !== 8'h33) begin
                bit_n = -1;
            end
        end else if (!pull_o && bit_n >= 8 && bit_n < 72) begin
            pull_o = ~ID_VALUE[bit_n - 8];
            bit_n++;
            #30000 pull_o = 1'b0;
        end
    end

    // ****************************************************************
    // reset detection and presence answer
    // ****************************************************************
    always @(posedge line_i) begin
        if ($realtime - fall_t >= 480000.0) begin
            rst_ns = $realtime - fall_t;
            bit_n = -1;
            if (present_i) begin
                #30000 pull_o = 1'b1;
                #120000 pull_o = 1'b0;
                bit_n = 0;
            end
        end
    end
endmodule

// *** verif/idbus_host_sva.sv ***
/*
 * Checker for the identity-bus host: bus handshake and line pulse widths.
 * Assumes it is bound to the host and sees only its ports.
 */
`timescale 1ns/1ps
module idbus_host_sva
    import idbus_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic line_i,
    input wire logic line_o,
    input wire logic line_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ****************************************************************
    // run lengths of the line drive
    // ****************************************************************
    int hi_cnt_reg;
    int lo_cnt_reg;
    logic after_rst_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hi_cnt_reg <= 0;
            lo_cnt_reg <= 0;
            after_rst_reg <= 1'b0;
        end else begin
            hi_cnt_reg <= line_oe_o ? hi_cnt_reg + 1 : 0;
            lo_cnt_reg <= line_oe_o ? 0 : lo_cnt_reg + 1;
            if (line_oe_o) begin
                after_rst_reg <= 1'b0;
            end else if (hi_cnt_reg > T_SLOT_CYC) begin
                after_rst_reg <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acknowledged next cycle");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_dat_quiet: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    a_ctrl_reads_zero: assert property (ack_o && $past(!we_i)
        && $past(adr_i) == REG_CTRL |-> dat_o == 32'h0)
        else $error("control register read not zero");
    a_line_only_low: assert property (line_o == 1'b0)
        else $error("line output not low");
    a_reset_low_len: assert property ($fell(line_oe_o)
        && hi_cnt_reg > T_SLOT_CYC |-> hi_cnt_reg >= T_RESET_CYC)
        else $error("reset pulse too short");
    a_slot_low_len: assert property ($fell(line_oe_o)
        && hi_cnt_reg <= T_SLOT_CYC |-> (hi_cnt_reg >= 50
        && hi_cnt_reg <= 750) || hi_cnt_reg >= 3000)
        else $error("slot low time out of range");
    a_presence_gap: assert property ($rose(line_oe_o)
        && after_rst_reg |-> lo_cnt_reg >= T_PPD_PP_MAX_CYC)
        else $error("drive during presence window");
    c_reset: cover property ($fell(line_oe_o) && hi_cnt_reg > T_SLOT_CYC);
    c_slot: cover property ($fell(line_oe_o) && hi_cnt_reg < 750);
    c_write: cover property (ack_o && $past(we_i));
endmodule

// *** verif/idbus_host_tb.sv ***
/*
 * Testbench for the identity-bus host: Wishbone tasks, device model on
 * the wire, register and identity-read checks.
 * Assumes the wire has a pull-up; both ends only pull low.
 */
`timescale 1ns/1ps
module idbus_host_tb;
    import idbus_pkg::*;

    // ****************************************************************
    // expected identity: family value is arbitrary
    // ****************************************************************
    function automatic logic [7:0] crc8(input logic [55:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 56; i++) begin
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
        end
        return c;
    endfunction
    localparam logic [55:0] ID_BODY = {48'h0123456789AB, 8'h5A};
    localparam logic [63:0] DEV_ID = {crc8(ID_BODY), ID_BODY};
    localparam int LIMIT = 600000;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [3:0] sel_i = 4'h0;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic line_o;
    logic line_oe_o;
    logic dev_pull;
    logic present_i = 1'b0;
    wire logic line_w;
    logic [31:0] q;
    int errors = 0;
    int compares = 0;
    int cycles = 0;

    always #10 clk_i = ~clk_i;
    assign line_w = ~(line_oe_o | dev_pull);

    idbus_host dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .line_i(line_w),
        .line_o(line_o), .line_oe_o(line_oe_o));
    idbus_dev_model #(.ID_VALUE(DEV_ID)) model_u (.line_i(line_w),
        .present_i(present_i), .pull_o(dev_pull));

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic complete_run;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] e);
        compares++;
        if (got !== e) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, e);
        end
    endtask

    task automatic check_flag(input logic f);
        compares++;
        if (f !== 1'b1) begin
            errors++;
            $display("MISMATCH %0t line check failed", $time);
        end
    endtask

    // holds the request until ack is sampled high, then drops it
    task automatic wb_xfer(input logic we, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        sel_i <= 4'h1;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic wait_idle(output logic [31:0] r);
        do wb_xfer(1'b0, REG_STATUS, 32'h0, r);
        while (!(r[ST_BUSY_BIT] === 1'b0 && r[ST_DONE_BIT] === 1'b1));
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            $display("MISMATCH %0t timeout", $time);
            complete_run;
        end
    end

    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_xfer(1'b0, 8'h20, 32'h0, q);
        check_word(q, 32'h0);
        wb_xfer(1'b1, REG_TXDATA, 32'h000000A5, q);
        wb_xfer(1'b0, REG_TXDATA, 32'h0, q);
        check_word(q & 32'hFF, 32'hA5);
        wb_xfer(1'b0, REG_CTRL, 32'h0, q);
        check_word(q, 32'h0);
        // silent line: identity read must be skipped
        wb_xfer(1'b1, REG_CTRL, 32'h3, q);
        wait_idle(q);
        check_word(q & 32'hB, 32'h8);
        present_i <= 1'b1;
        // reset only, then raw byte write and byte read
        wb_xfer(1'b1, REG_CTRL, 32'h1, q);
        wait_idle(q);
        check_word(q & 32'hF, 32'hA);
        wb_xfer(1'b1, REG_TXDATA, {24'h000000, CMD_READ_ID}, q);
        wb_xfer(1'b1, REG_CTRL, 32'h4, q);
        wait_idle(q);
        check_flag(model_u.cmd_bits === CMD_READ_ID);
        wb_xfer(1'b1, REG_CTRL, 32'h8, q);
        wait_idle(q);
        wb_xfer(1'b0, REG_RXDATA, 32'h0, q);
        check_word(q, {24'h000000, DEV_ID[7:0]});
        wb_xfer(1'b1, REG_CTRL, 32'h3, q);
        wait_idle(q);
        check_word(q & 32'hF, 32'hE);
        wb_xfer(1'b0, REG_ID_LO, 32'h0, q);
        check_word(q, DEV_ID[31:0]);
        wb_xfer(1'b0, REG_ID_HI, 32'h0, q);
        check_word(q, DEV_ID[63:32]);
        check_flag(model_u.cmd_bits === CMD_READ_ID);
        check_flag(model_u.rst_ns >= 480000.0);
        complete_run;
    end
endmodule

bind idbus_host idbus_host_sva chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .sel_i(sel_i),
    .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .line_i(line_i), .line_o(line_o), .line_oe_o(line_oe_o));
